// [cies_pkg.sv]
// Constants, types and reset state of the instruction execute subset.
// Assumes one core clock and one AHB-Lite master issuing word transfers.
// Functional notes
// - Each file select pointer is 16 bits and wraps on increment or decrement.
// - Pointer stepping during an indirect move leaves every status flag alone.
// - Indirect port has no storage; it reaches the file its pointer names.
// - Load-option copies the accumulator to the option register, one cycle, no flags.
// - Reset instruction performs a full reset, same as the hardware reset.
// - Return from interrupt pops stack to PC, sets global enable bit 7, two cycles.
// - Return from subroutine pops stack top to PC in two cycles, no flags.
// - Return with literal loads accumulator with immediate and PC from stack top.
// - Rotate left through carry; old carry to bit 0, bit 7 to carry.
// - Rotate right through carry; old carry to bit 7, bit 0 to carry.
// - Literal minus accumulator goes to accumulator; updates carry, nibble carry, zero.
// - File minus accumulator goes to destination; updates carry, nibble carry, zero.
// - Carry set when subtrahend not above minuend; nibble carry likewise on nibbles.
// - File minus accumulator minus inverted carry; updates carry, nibble carry, zero.
// - Sleep clears watchdog and prescaler, sets timeout flag, clears powerdown flag.
// - Nibble swap exchanges file nibbles into destination, no flag changes.
// - Direction load copies accumulator to port A, B or C for operand 5, 6, 7.
// - Literal xor updates accumulator and only the zero flag.
package cies_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses, low eight address bits decoded)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_ACC = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_OPTION = 8'h0C;
    localparam logic [7:0] ADDR_DIR = 8'h10;
    localparam logic [7:0] ADDR_FSR0 = 8'h14;
    localparam logic [7:0] ADDR_FSR1 = 8'h18;
    localparam logic [7:0] ADDR_IRQCTL = 8'h1C;
    localparam logic [7:0] ADDR_PC = 8'h20;
    localparam logic [7:0] ADDR_WDOG = 8'h24;
    localparam logic [1:0] FILE_WIN = 2'h1; // Window at 0x40..0x7C
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ----------------------------------------------------------------
    // Field positions and operand codes
    // ----------------------------------------------------------------
    localparam int CMD_W = 14;
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_PD = 3;
    localparam int ST_TMO = 4;
    localparam int ST_BUSY = 8;
    localparam int ST_SLEEP = 9;
    localparam int IRQ_GLOBAL_BIT = 7;
    localparam logic [3:0] IND0_FILE = 4'h0;
    localparam logic [3:0] IND1_FILE = 4'h1;
    localparam logic [2:0] DIR_SEL_A = 3'h5;
    localparam logic [2:0] DIR_SEL_B = 3'h6;
    localparam logic [2:0] DIR_SEL_C = 3'h7;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] OPTION_RST = 8'hFF;
    localparam logic [7:0] DIR_RST = 8'hFF;

    typedef enum logic [4:0] {
        OP_NOP = 5'b00000,
        OP_LOAD_OPTION = 5'b00001,
        OP_SOFT_RESET = 5'b00010,
        OP_RET_IRQ = 5'b00011,
        OP_RET_SUB = 5'b00100,
        OP_RET_LIT = 5'b00101,
        OP_ROT_LEFT = 5'b00110,
        OP_ROT_RIGHT = 5'b00111,
        OP_LIT_MINUS_ACC = 5'b01000,
        OP_FILE_MINUS_ACC = 5'b01001,
        OP_FILE_MINUS_BRW = 5'b01010,
        OP_NIBBLE_SWAP = 5'b01011,
        OP_DIR_LOAD = 5'b01100,
        OP_LIT_XOR = 5'b01101,
        OP_SLEEP = 5'b01110,
        OP_LOAD_ACC = 5'b01111,
        OP_STORE_FILE = 5'b10000,
        OP_PUSH = 5'b10001,
        OP_IND_STORE = 5'b10010
    } cies_op_t;

    typedef struct packed {
        logic dest;
        cies_op_t op;
        logic [7:0] lit;
    } cies_cmd_t;

    typedef struct packed {
        logic [7:0] acc;
        logic c;
        logic nibble_carry_flag;
        logic z;
        logic timeout_flag;
        logic powerdown_flag;
        logic [7:0] option_cfg;
        logic [7:0] direction_reg_port_a;
        logic [7:0] direction_reg_port_b;
        logic [7:0] direction_reg_port_c;
        logic [1:0][15:0] file_select_pointer;
        logic [7:0] irq_control;
        logic [14:0] pc;
        logic [15:0][14:0] stack;
        logic [3:0] sp;
        logic [15:0][7:0] files;
        logic [7:0] watchdog_counter;
        logic [7:0] wdog_pre;
        logic busy;
        logic asleep;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic [31:0] rdata;
    } cies_state_t;

    function automatic cies_state_t cies_rst_state();
        cies_state_t s;
        s = '0;
        s.option_cfg = OPTION_RST;
        s.direction_reg_port_a = DIR_RST;
        s.direction_reg_port_b = DIR_RST;
        s.direction_reg_port_c = DIR_RST;
        s.timeout_flag = 1'b1;
        s.powerdown_flag = 1'b1;
        return s;
    endfunction : cies_rst_state

    localparam cies_state_t CIES_ST_RST = cies_rst_state();

endpackage : cies_pkg

// [cies_core.sv]
// Execute unit for a subset of the core instruction set, AHB-Lite slave.
// Assumes a single master, word transfers, one 100 MHz clock hclk.
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module cies_core
    import cies_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);

    // ----------------------------------------------------------------
    // State and helpers
    // ----------------------------------------------------------------
    cies_state_t st_reg;
    cies_state_t st_next;
    cies_cmd_t cmd;
    logic dp_done;
    logic exec_now;
    logic addr_take;
    logic wrap;
    logic wr_dst;
    logic [7:0] res;
    logic [3:0] fidx;
    logic [7:0] fval;
    logic [9:0] subr;
    logic [14:0] stack_top;

    // Map a file operand to an array entry; ports 0 and 1 are pointers
    function automatic logic [3:0] file_index(
        input cies_state_t s,
        input logic [3:0] fa
    );
        logic [3:0] idx;
        idx = fa;
        if (fa == IND0_FILE) begin
            idx = s.file_select_pointer[0][3:0];
        end else if (fa == IND1_FILE) begin
            idx = s.file_select_pointer[1][3:0];
        end
        return idx;
    endfunction : file_index

    // Minuend minus subtrahend minus borrow, {carry, nibble carry, result}
    function automatic logic [9:0] sub_flags(
        input logic [7:0] m,
        input logic [7:0] s,
        input logic bin
    );
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, m} - {1'b0, s} - {8'h00, bin};
        low = {1'b0, m[3:0]} - {1'b0, s[3:0]} - {4'h0, bin};
        return {~full[8], ~low[4], full[7:0]};
    endfunction : sub_flags

    // Read data for one register offset
    function automatic logic [31:0] reg_read(
        input cies_state_t s,
        input logic [7:0] a
    );
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            ADDR_ACC: d[7:0] = s.acc;
            ADDR_STATUS: begin
                d[ST_C] = s.c;
                d[ST_DC] = s.nibble_carry_flag;
                d[ST_Z] = s.z;
                d[ST_PD] = s.powerdown_flag;
                d[ST_TMO] = s.timeout_flag;
                d[ST_BUSY] = s.busy;
                d[ST_SLEEP] = s.asleep;
            end
            ADDR_OPTION: d[7:0] = s.option_cfg;
            ADDR_DIR: d[23:0] = {s.direction_reg_port_c,
                s.direction_reg_port_b, s.direction_reg_port_a};
            ADDR_FSR0: d[15:0] = s.file_select_pointer[0];
            ADDR_FSR1: d[15:0] = s.file_select_pointer[1];
            ADDR_IRQCTL: d[7:0] = s.irq_control;
            ADDR_PC: d[19:0] = {s.sp, 1'b0, s.pc};
            ADDR_WDOG: d[15:0] = {s.wdog_pre, s.watchdog_counter};
            default: begin
                if (a[7:6] == FILE_WIN) begin
                    d[7:0] = s.files[a[5:2]];
                end
            end
        endcase
        return d;
    endfunction : reg_read

    // ----------------------------------------------------------------
    // Bus outputs
    // ----------------------------------------------------------------
    // Command write waits out the idle cycle of a return
    // idle cycle stall
    assign hreadyout = ~(st_reg.ap_valid & st_reg.ap_write
        & (st_reg.ap_addr == ADDR_CMD) & st_reg.busy);
    assign hresp = 1'b0;
    assign hrdata = st_reg.rdata;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        cmd = cies_cmd_t'(hwdata[CMD_W-1:0]);
        dp_done = st_reg.ap_valid & hready;
        exec_now = dp_done & st_reg.ap_write & (st_reg.ap_addr == ADDR_CMD);
        addr_take = hready & hsel & htrans[1] & (hsize == HSIZE_WORD);
        fidx = file_index(st_reg, cmd.lit[3:0]);
        fval = st_reg.files[fidx];
        stack_top = st_reg.stack[st_reg.sp - 4'h1];
    end

    // Register updates and instruction execution
    always_comb begin
        st_next = st_reg;
        st_next.busy = 1'b0;
        subr = 10'h000;
        res = 8'h00;
        wr_dst = 1'b0;
        // Watchdog prescaler and counter run freely
        {wrap, st_next.wdog_pre} = {1'b0, st_reg.wdog_pre} + 9'h001;
        st_next.watchdog_counter = st_reg.watchdog_counter + {7'h00, wrap};
        // Plain register writes in the data phase
        if (dp_done && st_reg.ap_write) begin
            case (st_reg.ap_addr)
                ADDR_ACC: st_next.acc = hwdata[7:0];
                ADDR_STATUS: {st_next.z, st_next.nibble_carry_flag,
                    st_next.c} = hwdata[2:0];
                ADDR_FSR0: st_next.file_select_pointer[0] = hwdata[15:0];
                ADDR_FSR1: st_next.file_select_pointer[1] = hwdata[15:0];
                ADDR_IRQCTL: st_next.irq_control = hwdata[7:0];
                default: begin
                    if (st_reg.ap_addr[7:6] == FILE_WIN) begin
                        st_next.files[st_reg.ap_addr[5:2]] = hwdata[7:0];
                    end
                end
            endcase
        end
        // Instruction execution
        if (exec_now) begin
            st_next.asleep = 1'b0;
            st_next.pc = st_reg.pc + 15'h0001;
            unique case (cmd.op)
                OP_NOP: ;
                OP_LOAD_OPTION: st_next.option_cfg = st_reg.acc;
                OP_SOFT_RESET: st_next = CIES_ST_RST;
                OP_RET_IRQ: begin
                    st_next.pc = stack_top;
                    st_next.sp = st_reg.sp - 4'h1;
                    st_next.irq_control[IRQ_GLOBAL_BIT] = 1'b1;
                    st_next.busy = 1'b1;
                end
                OP_RET_SUB: begin
                    st_next.pc = stack_top;
                    st_next.sp = st_reg.sp - 4'h1;
                    st_next.busy = 1'b1;
                end
                OP_RET_LIT: begin
                    st_next.acc = cmd.lit;
                    st_next.pc = stack_top;
                    st_next.sp = st_reg.sp - 4'h1;
                    st_next.busy = 1'b1;
                end
                OP_ROT_LEFT: begin
                    res = {fval[6:0], st_reg.c};
                    st_next.c = fval[7];
                    wr_dst = 1'b1;
                end
                OP_ROT_RIGHT: begin
                    res = {st_reg.c, fval[7:1]};
                    st_next.c = fval[0];
                    wr_dst = 1'b1;
                end
                OP_LIT_MINUS_ACC: begin
                    subr = sub_flags(cmd.lit, st_reg.acc, 1'b0);
                    st_next.acc = subr[7:0];
                end
                OP_FILE_MINUS_ACC: begin
                    subr = sub_flags(fval, st_reg.acc, 1'b0);
                    wr_dst = 1'b1;
                end
                OP_FILE_MINUS_BRW: begin
                    subr = sub_flags(fval, st_reg.acc, ~st_reg.c);
                    wr_dst = 1'b1;
                end
                OP_NIBBLE_SWAP: begin
                    res = {fval[3:0], fval[7:4]};
                    wr_dst = 1'b1;
                end
                OP_DIR_LOAD: begin
                    if (cmd.lit[2:0] == DIR_SEL_A) begin
                        st_next.direction_reg_port_a = st_reg.acc;
                    end else if (cmd.lit[2:0] == DIR_SEL_B) begin
                        st_next.direction_reg_port_b = st_reg.acc;
                    end else if (cmd.lit[2:0] == DIR_SEL_C) begin
                        st_next.direction_reg_port_c = st_reg.acc;
                    end
                end
                OP_LIT_XOR: begin
                    st_next.acc = st_reg.acc ^ cmd.lit;
                    st_next.z = ((st_reg.acc ^ cmd.lit) == 8'h00);
                end
                OP_SLEEP: begin
                    st_next.watchdog_counter = 8'h00;
                    st_next.wdog_pre = 8'h00;
                    st_next.timeout_flag = 1'b1;
                    st_next.powerdown_flag = 1'b0;
                    st_next.asleep = 1'b1;
                end
                OP_LOAD_ACC: st_next.acc = cmd.lit;
                OP_STORE_FILE: st_next.files[fidx] = st_reg.acc;
                // Call-like push for return targets
                OP_PUSH: begin
                    st_next.stack[st_reg.sp] = st_reg.pc + 15'h0001;
                    st_next.sp = st_reg.sp + 4'h1;
                    st_next.pc = {7'h00, cmd.lit};
                end
                OP_IND_STORE: begin
                    st_next.files[st_reg.file_select_pointer[cmd.lit[1]][3:0]]
                        = st_reg.acc;
                    if (cmd.lit[0]) begin
                        st_next.file_select_pointer[cmd.lit[1]] =
                            st_reg.file_select_pointer[cmd.lit[1]] - 16'h0001;
                    end else begin
                        st_next.file_select_pointer[cmd.lit[1]] =
                            st_reg.file_select_pointer[cmd.lit[1]] + 16'h0001;
                    end
                end
                default: ;
            endcase
            if (cmd.op == OP_LIT_MINUS_ACC || cmd.op == OP_FILE_MINUS_ACC ||
                cmd.op == OP_FILE_MINUS_BRW) begin
                st_next.c = subr[9];
                st_next.nibble_carry_flag = subr[8];
                st_next.z = (subr[7:0] == 8'h00);
                res = subr[7:0];
            end
            // Destination bit selects accumulator or file
            if (wr_dst) begin
                if (cmd.dest) begin
                    st_next.files[fidx] = res;
                end else begin
                    st_next.acc = res;
                end
            end
        end
        // Address phase capture and read data
        if (hready) begin
            st_next.ap_valid = addr_take;
            st_next.ap_write = hwrite;
            st_next.ap_addr = haddr[7:0];
            if (addr_take && !hwrite) begin
                st_next.rdata = reg_read(st_reg, haddr[7:0]);
            end
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= CIES_ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_fsr_step: assert property (exec_now && cmd.op == OP_IND_STORE &&
        cmd.lit[1:0] == 2'b00 |=> st_reg.file_select_pointer[0] ==
        $past(st_reg.file_select_pointer[0]) + 16'h0001)
        else $error("pointer step wrong");
    a_ind_flags: assert property (exec_now && cmd.op == OP_IND_STORE
        |=> $stable({st_reg.c, st_reg.nibble_carry_flag, st_reg.z}))
        else $error("indirect move changed flags");
    a_ind_target: assert property (exec_now && cmd.op == OP_STORE_FILE &&
        cmd.lit[3:0] == IND1_FILE |=> st_reg.files[$past(
        st_reg.file_select_pointer[1][3:0])] == $past(st_reg.acc))
        else $error("indirect port missed target");
    a_option_load: assert property (exec_now && cmd.op == OP_LOAD_OPTION
        |=> st_reg.option_cfg == $past(st_reg.acc) && !st_reg.busy)
        else $error("option load wrong");
    a_soft_reset: assert property (exec_now && cmd.op == OP_SOFT_RESET
        |=> st_reg.pc == 15'h0000 && st_reg.acc == 8'h00 &&
        st_reg.option_cfg == OPTION_RST && st_reg.powerdown_flag)
        else $error("soft reset incomplete");
    a_ret_irq: assert property (exec_now && cmd.op == OP_RET_IRQ
        |=> st_reg.irq_control[IRQ_GLOBAL_BIT] &&
        st_reg.pc == $past(stack_top) && st_reg.busy)
        else $error("irq return wrong");
    a_ret_sub: assert property (exec_now && cmd.op == OP_RET_SUB
        |=> st_reg.busy && st_reg.pc == $past(stack_top) ##1 !st_reg.busy)
        else $error("subroutine return timing wrong");
    a_ret_lit: assert property (exec_now && cmd.op == OP_RET_LIT
        |=> st_reg.acc == $past(cmd.lit) && st_reg.pc == $past(stack_top))
        else $error("literal return wrong");
    a_rot_left: assert property (exec_now && cmd.op == OP_ROT_LEFT &&
        !cmd.dest |=> st_reg.acc == {$past(fval[6:0]), $past(st_reg.c)}
        && st_reg.c == $past(fval[7]))
        else $error("rotate left wrong");
    a_rot_right: assert property (exec_now && cmd.op == OP_ROT_RIGHT &&
        !cmd.dest |=> st_reg.acc == {$past(st_reg.c), $past(fval[7:1])}
        && $stable(st_reg.z))
        else $error("rotate right wrong");
    a_sub_carry: assert property (exec_now && cmd.op == OP_LIT_MINUS_ACC
        |=> st_reg.c == ($past(st_reg.acc) <= $past(cmd.lit)) &&
        st_reg.nibble_carry_flag == ($past(st_reg.acc[3:0]) <=
        $past(cmd.lit[3:0])))
        else $error("subtract carry wrong");
    a_sleep_flags: assert property (exec_now && cmd.op == OP_SLEEP
        |=> st_reg.watchdog_counter == 8'h00 && st_reg.timeout_flag &&
        !st_reg.powerdown_flag)
        else $error("sleep side effects wrong");
    a_idle_stall: assert property (st_reg.busy |-> !exec_now)
        else $error("command taken in idle cycle");

    // Data path results
    a_file_sub: assert property (exec_now &&
        cmd.op == OP_FILE_MINUS_ACC && cmd.dest |=>
        st_reg.files[$past(fidx)] == $past(fval) - $past(st_reg.acc))
        else $error("file subtract wrong");
    a_swap_nibble: assert property (exec_now &&
        cmd.op == OP_NIBBLE_SWAP && !cmd.dest |=>
        st_reg.acc == {$past(fval[3:0]), $past(fval[7:4])} &&
        $stable({st_reg.c, st_reg.nibble_carry_flag, st_reg.z}))
        else $error("nibble swap wrong");
    a_xor_zero: assert property (exec_now && cmd.op == OP_LIT_XOR
        |=> st_reg.acc == ($past(st_reg.acc) ^ $past(cmd.lit)) &&
        st_reg.z == (st_reg.acc == 8'h00) && $stable(st_reg.c))
        else $error("literal xor wrong");
    a_dir_load: assert property (exec_now &&
        cmd.op == OP_DIR_LOAD && cmd.lit[2:0] == DIR_SEL_B |=>
        st_reg.direction_reg_port_b == $past(st_reg.acc))
        else $error("direction load wrong");

    c_ret_then_cmd: cover property (exec_now && cmd.op == OP_RET_SUB
        ##1 !hreadyout ##1 exec_now);
    c_fsr_wrap: cover property (exec_now && cmd.op == OP_IND_STORE &&
        st_reg.file_select_pointer[0] == 16'hFFFF);
    c_sub_borrow: cover property (exec_now && cmd.op == OP_FILE_MINUS_BRW
        && !st_reg.c);
    c_sleep: cover property (exec_now && cmd.op == OP_SLEEP);

endmodule : cies_core

// [cies_core_tb_top.sv]
// Self-checking bench for the instruction execute subset core.
// Assumes the core is the one AHB-Lite slave; hready follows hreadyout.
`timescale 1ns/10ps
module cies_core_tb_top
    import cies_pkg::*;
;
    // ------------------------------------------------------------
    // Bus signals and counters
    // ------------------------------------------------------------
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    int mismatches = 0;
    int cmp_count = 0;

    // Clock at 100 MHz
    always #5 hclk = ~hclk;

    cies_core dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata)
    );

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task give_verdict();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    // Waits for hready high, bounded; ends on the sampling edge
    task wait_rdy(output logic [31:0] q);
        int n;
        n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                mismatches++;
                give_verdict();
            end
            @(negedge hclk);
        end
        q = hrdata;
        if (hresp !== 1'b0) begin
            mismatches++;
            $display("mismatch hresp expected 0 seen %b", hresp);
        end
        @(posedge hclk);
    endtask : wait_rdy

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q);
        logic [31:0] dummy;
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy(dummy);
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy(q);
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task cmd(input logic dst, input cies_op_t op, input logic [7:0] lit);
        wr(ADDR_CMD, {18'h0, dst, op, lit});
    endtask : cmd

    // Reads after one idle cycle and compares the masked word
    task rck(input string nm, input logic [7:0] a, input logic [31:0] m,
             input logic [31:0] e);
        logic [31:0] q;
        @(posedge hclk);
        xfer(1'b0, a, 32'h0000_0000, q);
        cmp_count++;
        if ((q & m) !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, q & m);
        end
    endtask : rck

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // reset values
    task t_reset();
        wr(8'h30, 32'h0000_00FF);
        rck("unmapped", 8'h30, 32'hFFFF_FFFF, 32'h0000_0000);
        rck("status", ADDR_STATUS, 32'h0000_03FF, 32'h0000_0018);
        rck("dir", ADDR_DIR, 32'hFFFF_FFFF, 32'h00FF_FFFF);
    endtask : t_reset

    task t_config();
        wr(ADDR_ACC, 32'h0000_004F);
        wr(ADDR_STATUS, 32'h0000_0005);
        cmd(1'b0, OP_LOAD_OPTION, 8'h00);
        rck("option", ADDR_OPTION, 32'hFFFF_FFFF, 32'h0000_004F);
        for (int i = 5; i < 8; i++) begin
            wr(ADDR_ACC, 32'h0000_0010 + 32'(i));
            cmd(1'b0, OP_DIR_LOAD, 8'(i));
        end
        wr(ADDR_ACC, 32'h0000_00EE);
        cmd(1'b0, OP_DIR_LOAD, 8'h04);
        rck("dir", ADDR_DIR, 32'hFFFF_FFFF, 32'h0017_1615);
        rck("flags", ADDR_STATUS, 32'h0000_0007, 32'h0000_0005);
    endtask : t_config

    task t_rotate();
        wr(8'h48, 32'h0000_00E6);
        wr(ADDR_STATUS, 32'h0000_0000);
        cmd(1'b0, OP_ROT_LEFT, 8'h02);
        rck("acc", ADDR_ACC, 32'h0000_00FF, 32'h0000_00CC);
        rck("flags", ADDR_STATUS, 32'h0000_0007, 32'h0000_0001);
        cmd(1'b1, OP_ROT_RIGHT, 8'h02);
        rck("file", 8'h48, 32'h0000_00FF, 32'h0000_00F3);
        rck("flags", ADDR_STATUS, 32'h0000_0007, 32'h0000_0000);
    endtask : t_rotate

    task t_sub();
        wr(ADDR_ACC, 32'h0000_0010);
        cmd(1'b0, OP_LIT_MINUS_ACC, 8'h10);
        rck("flags", ADDR_STATUS, 32'h0000_0007, 32'h0000_0007);
        wr(ADDR_ACC, 32'h0000_0010);
        cmd(1'b0, OP_LIT_MINUS_ACC, 8'h0F);
        rck("acc", ADDR_ACC, 32'h0000_00FF, 32'h0000_00FF);
        rck("flags", ADDR_STATUS, 32'h0000_0007, 32'h0000_0002);
        wr(8'h4C, 32'h0000_0020);
        wr(ADDR_ACC, 32'h0000_0001);
        cmd(1'b1, OP_FILE_MINUS_ACC, 8'h03);
        rck("file", 8'h4C, 32'h0000_00FF, 32'h0000_001F);
        rck("flags", ADDR_STATUS, 32'h0000_0007, 32'h0000_0001);
        wr(ADDR_STATUS, 32'h0000_0000);
        cmd(1'b0, OP_FILE_MINUS_BRW, 8'h03);
        rck("acc", ADDR_ACC, 32'h0000_00FF, 32'h0000_001D);
        rck("flags", ADDR_STATUS, 32'h0000_0007, 32'h0000_0003);
    endtask : t_sub

    task t_swap_xor();
        wr(8'h50, 32'h0000_00A5);
        wr(ADDR_STATUS, 32'h0000_0003);
        cmd(1'b0, OP_NIBBLE_SWAP, 8'h04);
        rck("acc", ADDR_ACC, 32'h0000_00FF, 32'h0000_005A);
        rck("flags", ADDR_STATUS, 32'h0000_0007, 32'h0000_0003);
        cmd(1'b0, OP_LIT_XOR, 8'h5A);
        rck("acc", ADDR_ACC, 32'h0000_00FF, 32'h0000_0000);
        rck("flags", ADDR_STATUS, 32'h0000_0007, 32'h0000_0007);
    endtask : t_swap_xor

    task t_indirect();
        wr(ADDR_STATUS, 32'h0000_0005);
        wr(ADDR_FSR0, 32'h0000_FFFF);
        wr(ADDR_FSR1, 32'h0000_0000);
        wr(ADDR_ACC, 32'h0000_0077);
        cmd(1'b0, OP_IND_STORE, 8'h00);
        cmd(1'b0, OP_IND_STORE, 8'h03);
        rck("file15", 8'h7C, 32'h0000_00FF, 32'h0000_0077);
        rck("file0", 8'h40, 32'h0000_00FF, 32'h0000_0077);
        rck("fsr0", ADDR_FSR0, 32'hFFFF_FFFF, 32'h0000_0000);
        rck("fsr1", ADDR_FSR1, 32'hFFFF_FFFF, 32'h0000_FFFF);
        rck("flags", ADDR_STATUS, 32'h0000_0007, 32'h0000_0005);
        wr(ADDR_ACC, 32'h0000_003C);
        cmd(1'b0, OP_STORE_FILE, 8'h01);
        rck("indport", 8'h7C, 32'h0000_00FF, 32'h0000_003C);
    endtask : t_indirect

    // returns, then a command at once
    task t_returns();
        cmd(1'b0, OP_PUSH, 8'h30);
        cmd(1'b0, OP_PUSH, 8'h50);
        cmd(1'b0, OP_RET_LIT, 8'h99);
        rck("acc", ADDR_ACC, 32'h0000_00FF, 32'h0000_0099);
        rck("pc", ADDR_PC, 32'h0000_7FFF, 32'h0000_0031);
        cmd(1'b0, OP_PUSH, 8'h60);
        cmd(1'b0, OP_RET_IRQ, 8'h00);
        rck("irqctl", ADDR_IRQCTL, 32'h0000_0080, 32'h0000_0080);
        rck("pc", ADDR_PC, 32'h0000_7FFF, 32'h0000_0032);
        cmd(1'b0, OP_PUSH, 8'h70);
        cmd(1'b0, OP_RET_SUB, 8'h00);
        cmd(1'b0, OP_LOAD_ACC, 8'h42);
        rck("pc", ADDR_PC, 32'h0000_7FFF, 32'h0000_0034);
        rck("acc", ADDR_ACC, 32'h0000_00FF, 32'h0000_0042);
        rck("flags", ADDR_STATUS, 32'h0000_0007, 32'h0000_0005);
    endtask : t_returns

    task t_sleep_reset();
        repeat (300) @(posedge hclk);
        cmd(1'b0, OP_SLEEP, 8'h00);
        rck("wdog", ADDR_WDOG, 32'h0000_FFFF, 32'h0000_0100);
        rck("status", ADDR_STATUS, 32'h0000_0218, 32'h0000_0210);
        cmd(1'b0, OP_SOFT_RESET, 8'h00);
        rck("option", ADDR_OPTION, 32'hFFFF_FFFF, 32'h0000_00FF);
        rck("acc", ADDR_ACC, 32'hFFFF_FFFF, 32'h0000_0000);
        rck("status", ADDR_STATUS, 32'h0000_03FF, 32'h0000_0018);
    endtask : t_sleep_reset

    // Main sequence
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_config();
        t_rotate();
        t_sub();
        t_swap_xor();
        t_indirect();
        t_returns();
        t_sleep_reset();
        give_verdict();
    end
endmodule : cies_core_tb_top
